// ### include/mah_pkg.sv
// constants and types for the station address, hash table and phy management block
package mah_pkg;
    // =====================================================
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_ADDR_HIGH = 6'h02;
    localparam logic [5:0] IDX_ADDR_LOW = 6'h03;
    localparam logic [5:0] IDX_HASH_HIGH = 6'h04;
    localparam logic [5:0] IDX_HASH_LOW = 6'h05;
    localparam logic [5:0] IDX_MGMT_ACC = 6'h06;
    localparam logic [5:0] IDX_MGMT_DATA = 6'h07;
    localparam logic [5:0] IDX_MCAST_CTRL = 6'h09;
    // =====================================================
    // reset values
    localparam logic [31:0] RST_ADDR_LOW = 32'h0FFFFFFF;
    localparam logic [15:0] RST_ADDR_HIGH = 16'hFFFF;
    localparam logic [31:0] RST_HASH = 32'h00000000;
    // =====================================================
    // field positions
    localparam int ACC_PHY_LSB = 11;
    localparam int ACC_IDX_LSB = 6;
    localparam int ACC_WR_BIT = 1;
    localparam int ACC_BUSY_BIT = 0;
    localparam int CTRL_PASS_BIT = 0;
    localparam int CTRL_INIT_BIT = 8;
    // =====================================================
    // eeprom byte addresses of the station address
    localparam logic [2:0] EE_FIRST = 3'h1;
    localparam logic [2:0] EE_LOW_LAST = 3'h4;
    localparam logic [2:0] EE_HIGH_LAST = 3'h6;
    // =====================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {MM_IDLE, MM_REQ} mah_mstate_t;
endpackage

// ### logic/mah_regs.sv
// station address, multicast hash filter and phy management access registers
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module mah_regs
    import mah_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // eeprom controller load port
    input wire logic ee_byte_valid_i,
    input wire logic [2:0] ee_byte_addr_i,
    input wire logic [7:0] ee_byte_i,
    input wire logic ee_load_done_i,
    // receive filter port
    input wire logic frame_check_i,
    input wire logic [5:0] frame_hash_idx_i,
    input wire logic [47:0] rx_dest_addr_i,
    output logic filt_valid_o,
    output logic mcast_accept_o,
    output logic da_match_o,
    output logic [47:0] station_addr_o,
    // internal phy management port
    output logic phy_req_o,
    output logic phy_write_select_o,
    output logic [4:0] phy_addr_o,
    output logic [4:0] phy_reg_index_o,
    output logic [15:0] phy_wdata_o,
    input wire logic phy_ack_i,
    input wire logic [15:0] phy_rdata_i
);
    // =====================================================
    // state
    typedef struct packed {
        logic [31:0] addr_lo;
        logic [15:0] addr_hi;
        logic [31:0] hash_hi;
        logic [31:0] hash_lo;
        logic [4:0] phy_addr;
        logic [4:0] reg_idx;
        logic wr;
        logic busy;
        logic [15:0] mdata;
        logic pass_all;
        logic init_done;
        mah_mstate_t mst;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic filt_valid;
        logic mcast_accept;
        logic da_match;
    } mah_state_t;

    mah_state_t st_r;
    mah_state_t st_nxt;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_wr;
    logic acc_go;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [47:0] station;

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // =====================================================
    // handshakes and write operand selection
    assign s_axi_awready_o = !st_r.aw_have && !st_r.bvalid;
    assign s_axi_wready_o = !st_r.w_have && !st_r.bvalid;
    assign s_axi_arready_o = !st_r.rvalid;
    assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
    assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
    assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
    assign do_wr = (st_r.aw_have || aw_hs) && (st_r.w_have || w_hs);
    assign wr_addr = st_r.aw_have ? st_r.aw_addr : s_axi_awaddr_i;
    assign wr_data = st_r.w_have ? st_r.wdata : s_axi_wdata_i;
    assign wr_strb = st_r.w_have ? st_r.wstrb : s_axi_wstrb_i;
    assign station = {st_r.addr_hi, st_r.addr_lo};
    // a start is an accepted access-register write with busy set while idle
    assign acc_go = do_wr && wr_addr[1:0] == 2'h0 && wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_MGMT_ACC)
                    && !st_r.busy && wr_strb[0] && wr_data[ACC_BUSY_BIT];

    // =====================================================
    // next-state logic
    always_comb begin
        logic [31:0] acc_word;
        logic [31:0] mw;
        acc_word = 32'h00000000;
        mw = 32'h00000000;
        st_nxt = st_r;
        // write channel capture
        if (aw_hs && !do_wr) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr_i;
        end
        if (w_hs && !do_wr) begin
            st_nxt.w_have = 1'b1;
            st_nxt.wdata = s_axi_wdata_i;
            st_nxt.wstrb = s_axi_wstrb_i;
        end
        if (st_r.bvalid && s_axi_bready_i) begin
            st_nxt.bvalid = 1'b0;
        end
        // init completes once, on the eeprom controller's done level
        if (ee_load_done_i) begin
            st_nxt.init_done = 1'b1;
        end
        // register write
        if (do_wr) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            if (wr_addr[1:0] == 2'h0 && wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_ADDR_LOW)) begin
                if (st_r.init_done) begin
                    st_nxt.addr_lo = merge(st_r.addr_lo, wr_data, wr_strb);
                end
            end else if (wr_addr[1:0] == 2'h0 && wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_ADDR_HIGH)) begin
                if (st_r.init_done) begin
                    mw = merge({16'h0000, st_r.addr_hi}, wr_data, wr_strb);
                    st_nxt.addr_hi = mw[15:0];
                end
            end else if (wr_addr[1:0] == 2'h0 && wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_HASH_HIGH)) begin
                st_nxt.hash_hi = merge(st_r.hash_hi, wr_data, wr_strb);
            end else if (wr_addr[1:0] == 2'h0 && wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_HASH_LOW)) begin
                st_nxt.hash_lo = merge(st_r.hash_lo, wr_data, wr_strb);
            end else if (wr_addr[1:0] == 2'h0 && wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_MGMT_ACC)) begin
                // writes while busy are dropped so the running access keeps its fields
                if (!st_r.busy) begin
                    acc_word = {16'h0000, st_r.phy_addr, st_r.reg_idx, 4'h0, st_r.wr, 1'b0};
                    acc_word = merge(acc_word, wr_data, wr_strb);
                    st_nxt.phy_addr = acc_word[ACC_PHY_LSB +: 5];
                    st_nxt.reg_idx = acc_word[ACC_IDX_LSB +: 5];
                    st_nxt.wr = acc_word[ACC_WR_BIT];
                    st_nxt.busy = acc_word[ACC_BUSY_BIT];
                end
            end else if (wr_addr[1:0] == 2'h0 && wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_MGMT_DATA)) begin
                if (!st_r.busy) begin
                    mw = merge({16'h0000, st_r.mdata}, wr_data, wr_strb);
                    st_nxt.mdata = mw[15:0];
                end
            end else if (wr_addr[1:0] == 2'h0 && wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_MCAST_CTRL)) begin
                if (wr_strb[0]) begin
                    st_nxt.pass_all = wr_data[CTRL_PASS_BIT];
                end
            end else begin
                st_nxt.bresp = RESP_SLVERR;
            end
        end
        // eeprom power-on load, byte 1 lowest
        if (ee_byte_valid_i && !st_r.init_done) begin
            if (ee_byte_addr_i >= EE_FIRST && ee_byte_addr_i <= EE_LOW_LAST) begin
                st_nxt.addr_lo[(ee_byte_addr_i - EE_FIRST)*8 +: 8] = ee_byte_i;
            end else if (ee_byte_addr_i > EE_LOW_LAST && ee_byte_addr_i <= EE_HIGH_LAST) begin
                st_nxt.addr_hi[(ee_byte_addr_i - EE_LOW_LAST - 3'h1)*8 +: 8] = ee_byte_i;
            end
        end
        // register read
        if (st_r.rvalid && s_axi_rready_i) begin
            st_nxt.rvalid = 1'b0;
        end
        if (ar_hs) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            st_nxt.rdata = 32'h00000000;
            if (s_axi_araddr_i[1:0] != 2'h0) begin
                st_nxt.rresp = RESP_SLVERR;
            end else if (s_axi_araddr_i[ADDR_W-1:2] == (ADDR_W-2)'(IDX_ADDR_LOW)) begin
                st_nxt.rdata = st_r.addr_lo;
            end else if (s_axi_araddr_i[ADDR_W-1:2] == (ADDR_W-2)'(IDX_ADDR_HIGH)) begin
                st_nxt.rdata = {16'h0000, st_r.addr_hi};
            end else if (s_axi_araddr_i[ADDR_W-1:2] == (ADDR_W-2)'(IDX_HASH_HIGH)) begin
                st_nxt.rdata = st_r.hash_hi;
            end else if (s_axi_araddr_i[ADDR_W-1:2] == (ADDR_W-2)'(IDX_HASH_LOW)) begin
                st_nxt.rdata = st_r.hash_lo;
            end else if (s_axi_araddr_i[ADDR_W-1:2] == (ADDR_W-2)'(IDX_MGMT_ACC)) begin
                st_nxt.rdata = {16'h0000, st_r.phy_addr, st_r.reg_idx, 4'h0, st_r.wr, st_r.busy};
            end else if (s_axi_araddr_i[ADDR_W-1:2] == (ADDR_W-2)'(IDX_MGMT_DATA)) begin
                st_nxt.rdata = {16'h0000, st_r.mdata};
            end else if (s_axi_araddr_i[ADDR_W-1:2] == (ADDR_W-2)'(IDX_MCAST_CTRL)) begin
                st_nxt.rdata = {23'h000000, st_r.init_done, 7'h00, st_r.pass_all};
            end else begin
                st_nxt.rresp = RESP_SLVERR;
            end
        end
        // phy management sequencer: one request per start
        case (st_r.mst)
            MM_IDLE: begin
                if (acc_go) begin
                    st_nxt.mst = MM_REQ;
                end
            end
            MM_REQ: begin
                if (phy_ack_i) begin
                    st_nxt.mst = MM_IDLE;
                    st_nxt.busy = 1'b0;
                    if (!st_r.wr) begin
                        st_nxt.mdata = phy_rdata_i;
                    end
                end
            end
            default: begin
                st_nxt.mst = MM_IDLE;
            end
        endcase
        // receive filter decisions
        st_nxt.filt_valid = frame_check_i;
        if (frame_check_i) begin
            st_nxt.mcast_accept = st_r.pass_all || (frame_hash_idx_i[5] ? st_r.hash_hi[frame_hash_idx_i[4:0]]
                                  : st_r.hash_lo[frame_hash_idx_i[4:0]]);
            st_nxt.da_match = rx_dest_addr_i == station;
        end
    end

    // =====================================================
    // state register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.addr_lo <= RST_ADDR_LOW;
            st_r.addr_hi <= RST_ADDR_HIGH;
            st_r.hash_hi <= RST_HASH;
            st_r.hash_lo <= RST_HASH;
            st_r.mst <= MM_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =====================================================
    // outputs
    assign s_axi_bvalid_o = st_r.bvalid;
    assign s_axi_bresp_o = st_r.bresp;
    assign s_axi_rvalid_o = st_r.rvalid;
    assign s_axi_rdata_o = st_r.rdata;
    assign s_axi_rresp_o = st_r.rresp;
    assign filt_valid_o = st_r.filt_valid;
    assign mcast_accept_o = st_r.mcast_accept;
    assign da_match_o = st_r.da_match;
    assign station_addr_o = station;
    assign phy_req_o = st_r.mst == MM_REQ;
    assign phy_write_select_o = st_r.wr;
    assign phy_addr_o = st_r.phy_addr;
    assign phy_reg_index_o = st_r.reg_idx;
    assign phy_wdata_o = st_r.mdata;

    // =====================================================
    // assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    AST_START: assert property (acc_go |=> phy_req_o && st_r.busy)
        else $error("start did not raise phy request");
    AST_ONE_REQ: assert property (phy_req_o && phy_ack_i |=> !phy_req_o && !st_r.busy)
        else $error("busy or request stayed after phy ack");
    AST_REQ_HOLD: assert property (phy_req_o && !phy_ack_i |=> phy_req_o
        && $stable(phy_reg_index_o) && $stable(phy_write_select_o))
        else $error("phy request fields changed before ack");
    AST_RD_DATA: assert property (phy_req_o && phy_ack_i && !phy_write_select_o
        |=> st_r.mdata == $past(phy_rdata_i))
        else $error("phy read data not deposited");
    AST_WR_KEEP: assert property (phy_req_o && phy_write_select_o |=> $stable(phy_wdata_o))
        else $error("phy write data changed during access");
    AST_PASS_ALL: assert property (frame_check_i && st_r.pass_all |=> mcast_accept_o)
        else $error("pass-all frame rejected");
    AST_HASH_TOP: assert property (frame_check_i && !st_r.pass_all && frame_hash_idx_i == 6'h3F
        |=> mcast_accept_o == $past(st_r.hash_hi[31]))
        else $error("index 63 did not use high bit 31");
    AST_HASH_BOT: assert property (frame_check_i && !st_r.pass_all && frame_hash_idx_i == 6'h00
        |=> mcast_accept_o == $past(st_r.hash_lo[0]))
        else $error("index 0 did not use low bit 0");
    AST_EE_FIRST: assert property (ee_byte_valid_i && !st_r.init_done && ee_byte_addr_i == 3'h1
        |=> station_addr_o[7:0] == $past(ee_byte_i))
        else $error("eeprom byte 1 not in low bits");
    AST_EE_LAST: assert property (ee_byte_valid_i && !st_r.init_done && ee_byte_addr_i == 3'h6
        |=> station_addr_o[47:40] == $past(ee_byte_i))
        else $error("eeprom byte 6 not in high byte");
    AST_LOCK: assert property (!st_r.init_done && !ee_byte_valid_i |=> $stable(st_r.addr_lo))
        else $error("address changed before init");
    AST_DA: assert property (frame_check_i && rx_dest_addr_i == station_addr_o |=> da_match_o)
        else $error("own address not matched");
    AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped");

    COV_PHY_RD: cover property (acc_go ##1 phy_req_o [*2] ##1 !phy_req_o);
    COV_HASH_HIT: cover property (frame_check_i && !st_r.pass_all ##1 mcast_accept_o);
    COV_EE_LOAD: cover property (ee_byte_valid_i ##1 ee_load_done_i ##1 st_r.init_done);
endmodule

// ### test/mah_phy_model.sv
// behavioural responder standing in for the internal phy management port
`timescale 1ns/1ps
module mah_phy_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic wr_i,
    input wire logic [4:0] addr_i,
    input wire logic [4:0] idx_i,
    input wire logic [15:0] wdata_i,
    input wire logic [7:0] delay_i,
    input wire logic [15:0] rword_i,
    output logic ack_o,
    output logic [15:0] rdata_o,
    output logic [26:0] seen_o,
    output logic [7:0] count_o
);
    logic [7:0] wait_r;
    // ==========================================================
    // answer each request after delay_i cycles, one ack pulse only
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wait_r <= 8'h00;
            ack_o <= 1'b0;
            rdata_o <= 16'h5A5A;
            seen_o <= 27'h0;
            count_o <= 8'h00;
        end else if (ack_o) begin
            ack_o <= 1'b0;
            wait_r <= 8'h00;
            rdata_o <= ~rdata_o;
        end else if (req_i && wait_r == delay_i) begin
            ack_o <= 1'b1;
            rdata_o <= rword_i;
            seen_o <= {wr_i, addr_i, idx_i, wdata_i};
            count_o <= count_o + 8'h01;
        end else begin
            wait_r <= req_i ? wait_r + 8'h01 : 8'h00;
            rdata_o <= ~rdata_o; // read word only valid with ack
        end
    end
endmodule

// ### test/mah_regs_tb.sv
// self-checking bench for the address, hash filter and phy access registers
`timescale 1ns/1ps
module mah_regs_tb;
    import mah_pkg::*;
    logic clk, rst, awv, wv, bre, arv, rre, eev, eed, fchk;
    logic awr, wr, bv, arr, rv, fv, acc, dam, preq, pwr, pack;
    logic [7:0] awa, ara, eeb, dly, pcnt;
    logic [31:0] wd, rd, rdv;
    logic [3:0] ws;
    logic [1:0] br, rr, resp;
    logic [2:0] eea;
    logic [5:0] fidx;
    logic [47:0] rxda, sta;
    logic [4:0] pad, pix;
    logic [15:0] pwd, prd, rword;
    logic [26:0] pseen;
    int fail_count, n_tests, cyc;
    // ==========================================================
    // design and phy responder
    mah_regs #(.ADDR_W(8)) i_dut (.mclk_i(clk), .rst_i(rst),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rre), .ee_byte_valid_i(eev), .ee_byte_addr_i(eea), .ee_byte_i(eeb),
        .ee_load_done_i(eed), .frame_check_i(fchk), .frame_hash_idx_i(fidx), .rx_dest_addr_i(rxda),
        .filt_valid_o(fv), .mcast_accept_o(acc), .da_match_o(dam), .station_addr_o(sta),
        .phy_req_o(preq), .phy_write_select_o(pwr), .phy_addr_o(pad), .phy_reg_index_o(pix),
        .phy_wdata_o(pwd), .phy_ack_i(pack), .phy_rdata_i(prd));
    mah_phy_model i_phy (.mclk_i(clk), .rst_i(rst), .req_i(preq), .wr_i(pwr), .addr_i(pad),
        .idx_i(pix), .wdata_i(pwd), .delay_i(dly), .rword_i(rword), .ack_o(pack), .rdata_o(prd),
        .seen_o(pseen), .count_o(pcnt));
    // ==========================================================
    // shared tasks
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // write one word, address and data offered together
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ad, dd, hb;
        ad = 1'b0;
        dd = 1'b0;
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!(ad && dd)) begin
            @(negedge clk);
            ad |= awv && awr;
            dd |= wv && wr;
            @(posedge clk);
            if (ad) awv <= 1'b0;
            if (dd) wv <= 1'b0;
        end
        do begin
            @(negedge clk);
            resp = br;
            hb = bv;
            @(posedge clk);
        end while (!hb);
        bre <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        logic hs;
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(negedge clk);
            hs = arr;
            @(posedge clk);
        end while (!hs);
        arv <= 1'b0;
        do begin
            @(negedge clk);
            rdv = rd;
            resp = rr;
            hs = rv;
            @(posedge clk);
        end while (!hs);
        rre <= 1'b0;
        @(posedge clk);
    endtask
    // one filter evaluation, result one cycle later
    task automatic frame(input logic [5:0] x);
        fchk <= 1'b1;
        fidx <= x;
        @(posedge clk);
        fchk <= 1'b0;
        @(negedge clk);
        check(fv, 1'b1);
        @(posedge clk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] am [8] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h2C};
        logic [31:0] ex [8] = '{32'h0000FFFF, 32'h0FFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++) begin
            rd_reg(am[i]);
            check(rdv, ex[i]);
            check(resp, i == 7 ? RESP_SLVERR : RESP_OKAY);
        end
        // unmapped index answers an error and changes nothing
        wr_reg(8'h2C, 32'hFFFFFFFF, 4'hF);
        check(resp, RESP_SLVERR);
    endtask
    task automatic t_eeprom();
        wr_reg(8'h0C, 32'h11111111, 4'hF);
        check(resp, RESP_OKAY);
        rd_reg(8'h0C);
        check(rdv, 32'h0FFFFFFF);
        for (int i = 1; i <= 6; i++) begin
            eev <= 1'b1;
            eea <= 3'(i);
            eeb <= 8'(8'h12 + 8'h22 * (i - 1));
            @(posedge clk);
        end
        eev <= 1'b0;
        @(negedge clk);
        check(sta, 48'hBC9A78563412);
        // bus requests start just after a rising edge
        @(posedge clk);
        rd_reg(8'h0C);
        check(rdv, 32'h78563412);
        rd_reg(8'h08);
        check(rdv, 32'h0000BC9A);
        eed <= 1'b1;
        @(posedge clk);
        eed <= 1'b0;
        rd_reg(8'h24);
        check(rdv, 32'h00000100);
        wr_reg(8'h0C, 32'hA5A5A5A5, 4'hF);
        eev <= 1'b1;
        eea <= 3'h1;
        @(posedge clk);
        eev <= 1'b0;
        rd_reg(8'h0C);
        check(rdv, 32'hA5A5A5A5);
        rxda <= 48'hBC9AA5A5A5A5;
        frame(6'h00);
        check(dam, 1'b1);
        rxda <= 48'hBC9AA5A5A5A4;
        frame(6'h00);
        check(dam, 1'b0);
    endtask
    task automatic t_hash();
        logic [5:0] ix [5] = '{6'h00, 6'h08, 6'h3F, 6'h3E, 6'h20};
        logic ex [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        wr_reg(8'h10, 32'h80000000, 4'hF);
        check(resp, RESP_OKAY);
        wr_reg(8'h14, 32'hFFFFFFFF, 4'h1);
        // a misaligned write is refused and must not reach the high half
        wr_reg(8'h11, 32'hFFFFFFFF, 4'hF);
        check(resp, RESP_SLVERR);
        rd_reg(8'h14);
        check(rdv, 32'h000000FF);
        for (int i = 0; i < 5; i++) begin
            frame(ix[i]);
            check(acc, ex[i]);
        end
        wr_reg(8'h24, 32'h00000001, 4'hF);
        frame(6'h3E);
        check(acc, 1'b1);
    endtask
    // one phy access; d is the responder delay, w the word moved
    task automatic t_phy(input logic wrt, input logic [4:0] ix, input logic [15:0] w, input logic [7:0] d);
        logic [7:0] n0;
        n0 = pcnt;
        dly <= d;
        rword <= w;
        if (wrt) wr_reg(8'h1C, {16'h0000, w}, 4'hF);
        wr_reg(8'h18, {16'h0000, 5'h01, ix, 4'h0, wrt, 1'b1}, 4'hF);
        check(resp, RESP_OKAY);
        @(negedge clk);
        check(preq, d != 8'h00);
        if (d != 8'h00 && wrt) check({pwr, pad, pix, pwd}, {1'b1, 5'h01, ix, w});
        // bus requests start just after a rising edge
        @(posedge clk);
        rd_reg(8'h18);
        check(rdv[0], d != 8'h00);
        while (rdv[0] !== 1'b0) rd_reg(8'h18);
        check(pcnt, n0 + 8'h01);
        check(pseen[26:16], {wrt, 5'h01, ix});
        if (wrt) check(pseen[15:0], w);
        rd_reg(8'h1C);
        check(rdv, {16'h0000, w});
    endtask
    // ==========================================================
    // clock, timeout and main sequence
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        {rst, awv, wv, bre, arv, rre, eev, eed, fchk} = 9'h100;
        {awa, ara, eeb, dly, wd, ws, eea, fidx, rxda, rword} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_eeprom();
        t_hash();
        t_phy(1'b1, 5'h1B, 16'hC3A5, 8'h06);
        t_phy(1'b0, 5'h02, 16'h7E81, 8'h00);
        final_report();
    end
endmodule
